// file: hw/srse_pkg.sv
// Shared types and constants for the subtract, rotate and sleep executor
package srse_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int RADDR_W = 4;
	localparam int PRESC_W = 7;
	localparam int WDG_W = 8;
	localparam int NIB_W = 4;

	// ****************************************************************
	// Register indices on the plain register port
	// ****************************************************************
	localparam logic [RADDR_W-1:0] REG_ACC = 4'h0;
	localparam logic [RADDR_W-1:0] REG_CTRL = 4'h1;
	localparam logic [RADDR_W-1:0] REG_STATUS = 4'h2;
	localparam logic [RADDR_W-1:0] REG_WATCHDOG = 4'h3;

	// Control register bits
	localparam int CTRL_WAKE_BIT = 0;
	localparam int CTRL_WDG_EN_BIT = 1;

	// Status register bits
	localparam int ST_CARRY_BIT = 0;
	localparam int ST_NIBBLE_BIT = 1;
	localparam int ST_ZERO_BIT = 2;
	localparam int ST_PWR_DOWN_BIT = 3;
	localparam int ST_TIMEOUT_BIT = 4;
	localparam int ST_SLEEP_BIT = 5;

	// ****************************************************************
	// Reset, clear, step and last-count values
	// ****************************************************************
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
	localparam logic [WDG_W-1:0] WDG_CLEAR = 8'h00;
	localparam logic [WDG_W-1:0] WDG_STEP = 8'h01;
	localparam logic [PRESC_W-1:0] PRESC_CLEAR = 7'h00;
	localparam logic [PRESC_W-1:0] PRESC_STEP = 7'h01;
	localparam logic [PRESC_W-1:0] PRESC_LAST = 7'h7f;
	localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		SRSE_OP_ROTATE,
		SRSE_OP_SUB_LIT,
		SRSE_OP_SUB_FILE,
		SRSE_OP_SLEEP
	} srse_op_t;

	typedef enum logic {
		SRSE_RUN,
		SRSE_ASLEEP
	} srse_mode_t;

	// Operand is the literal or the file value the decoder fetched
	typedef struct packed {
		logic valid;
		srse_op_t op;
		logic dest;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] operand;
	} srse_instr_t;

	typedef struct packed {
		logic we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} srse_file_wr_t;

	typedef struct packed {
		logic carry;
		logic nibble_carry_flag;
		logic zero;
		logic power_down_flag;
		logic timeout_flag;
	} srse_flags_t;

	typedef struct packed {
		srse_mode_t mode;
		logic [DATA_W-1:0] acc;
		srse_flags_t flags;
		logic watchdog_en;
		logic [WDG_W-1:0] watchdog_counter;
		logic [PRESC_W-1:0] prescaler;
		srse_file_wr_t file_wr;
		logic [DATA_W-1:0] rdata;
	} srse_state_t;

endpackage : srse_pkg

// file: hw/srse_exec.sv
// Executor for subtract, rotate-right and power-down instructions
`timescale 1ns/1ps

// What this block does
// RQ1 - Power-down clears power flag, sets timeout flag
// RQ2 - Power-down zeroes watchdog counter and prescaler
// RQ3 - Power-down halts oscillator, enters sleep
// RQ4 - Rotate right through carry, only carry changes
// RQ5 - Rotate destination: zero accumulator, one file
// RQ6 - Literal minus accumulator into accumulator
// RQ7 - Literal subtract carry and nibble carry borrows
// RQ8 - File minus accumulator, carry and nibble borrows
// RQ9 - File subtract destination: accumulator or file
// RQ10 - Subtract zero flag follows eight-bit result
module srse_exec (
	input wire logic clk_sys,
	input wire logic rst,
	input wire srse_pkg::srse_instr_t instr,
	input wire logic [srse_pkg::RADDR_W-1:0] reg_addr,
	input wire logic [srse_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [srse_pkg::DATA_W-1:0] reg_rdata,
	output logic [srse_pkg::DATA_W-1:0] acc,
	output srse_pkg::srse_flags_t flags,
	output srse_pkg::srse_file_wr_t file_wr,
	output logic osc_stop
);

	srse_pkg::srse_state_t q;
	srse_pkg::srse_state_t d;
	logic run_now;
	logic issued;
	logic acc_wr;
	logic ctrl_wr;
	logic wake_wr;

	assign run_now = (q.mode == srse_pkg::SRSE_RUN);
	assign issued = instr.valid && run_now;
	assign acc_wr = reg_wr && (reg_addr == srse_pkg::REG_ACC);
	assign ctrl_wr = reg_wr && (reg_addr == srse_pkg::REG_CTRL);
	assign wake_wr = ctrl_wr && reg_wdata[srse_pkg::CTRL_WAKE_BIT];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [srse_pkg::DATA_W:0] diff;
		logic [srse_pkg::NIB_W:0] ndiff;
		logic [srse_pkg::DATA_W-1:0] res;
		diff = {1'b0, instr.operand} - {1'b0, q.acc};
		ndiff = {1'b0, instr.operand[srse_pkg::NIB_W-1:0]}
			- {1'b0, q.acc[srse_pkg::NIB_W-1:0]};
		res = diff[srse_pkg::DATA_W-1:0];
		d = q;
		d.file_wr.we = 1'b0;
		d.rdata = srse_pkg::RDATA_IDLE;

		// Watchdog keeps counting only while awake and enabled
		if (q.watchdog_en && run_now) begin
			d.prescaler = q.prescaler + srse_pkg::PRESC_STEP;
			if (q.prescaler == srse_pkg::PRESC_LAST) begin
				d.watchdog_counter = q.watchdog_counter
					+ srse_pkg::WDG_STEP;
			end
		end

		case (q.mode)
			srse_pkg::SRSE_RUN: begin
				if (instr.valid) begin
					case (instr.op)
						srse_pkg::SRSE_OP_ROTATE: begin
							// RQ4 rotate through carry
							res = {q.flags.carry,
								instr.operand[srse_pkg::DATA_W-1:1]};
							d.flags.carry = instr.operand[0];
						end
						srse_pkg::SRSE_OP_SUB_LIT,
						srse_pkg::SRSE_OP_SUB_FILE: begin
							// RQ7 borrow flags inverted
							// RQ8 same flags for file form
							d.flags.carry = ~diff[srse_pkg::DATA_W];
							d.flags.nibble_carry_flag =
								~ndiff[srse_pkg::NIB_W];
							// RQ10 zero from result
							d.flags.zero = (res == srse_pkg::ACC_RST);
						end
						srse_pkg::SRSE_OP_SLEEP: begin
							// RQ1 status bits on power-down
							d.flags.power_down_flag = 1'b0;
							d.flags.timeout_flag = 1'b1;
							// RQ2 watchdog and prescaler cleared
							d.watchdog_counter = srse_pkg::WDG_CLEAR;
							d.prescaler = srse_pkg::PRESC_CLEAR;
							// RQ3 stop oscillator
							d.mode = srse_pkg::SRSE_ASLEEP;
						end
						default: begin
						end
					endcase
					if (instr.op == srse_pkg::SRSE_OP_SUB_LIT) begin
						// RQ6 literal form always lands in accumulator
						d.acc = res;
					end else if (instr.op != srse_pkg::SRSE_OP_SLEEP)
					begin
						// RQ5 rotate destination select
						// RQ9 subtract destination select
						if (instr.dest) begin
							d.file_wr.we = 1'b1;
							d.file_wr.addr = instr.addr;
							d.file_wr.data = res;
						end else begin
							d.acc = res;
						end
					end
				end
			end
			srse_pkg::SRSE_ASLEEP: begin
				if (wake_wr) begin
					d.mode = srse_pkg::SRSE_RUN;
				end
			end
			default: begin
				d.mode = srse_pkg::SRSE_RUN;
			end
		endcase

		// ************************************************************
		// Register port; software writes win over the instruction
		// ************************************************************
		if (acc_wr) begin
			d.acc = reg_wdata;
		end else if (ctrl_wr) begin
			d.watchdog_en = reg_wdata[srse_pkg::CTRL_WDG_EN_BIT];
		end

		if (reg_rd) begin
			if (reg_addr == srse_pkg::REG_ACC) begin
				d.rdata = q.acc;
			end else if (reg_addr == srse_pkg::REG_CTRL) begin
				d.rdata[srse_pkg::CTRL_WDG_EN_BIT] = q.watchdog_en;
			end else if (reg_addr == srse_pkg::REG_STATUS) begin
				d.rdata[srse_pkg::ST_CARRY_BIT] = q.flags.carry;
				d.rdata[srse_pkg::ST_NIBBLE_BIT] =
					q.flags.nibble_carry_flag;
				d.rdata[srse_pkg::ST_ZERO_BIT] = q.flags.zero;
				d.rdata[srse_pkg::ST_PWR_DOWN_BIT] =
					q.flags.power_down_flag;
				d.rdata[srse_pkg::ST_TIMEOUT_BIT] = q.flags.timeout_flag;
				d.rdata[srse_pkg::ST_SLEEP_BIT] = ~run_now;
			end else if (reg_addr == srse_pkg::REG_WATCHDOG) begin
				d.rdata = q.watchdog_counter;
			end else begin
				d.rdata = srse_pkg::RDATA_IDLE;
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q.mode <= srse_pkg::SRSE_RUN;
			q.acc <= srse_pkg::ACC_RST;
			q.flags.carry <= 1'b0;
			q.flags.nibble_carry_flag <= 1'b0;
			q.flags.zero <= 1'b0;
			q.flags.power_down_flag <= 1'b1;
			q.flags.timeout_flag <= 1'b1;
			q.watchdog_en <= 1'b0;
			q.watchdog_counter <= srse_pkg::WDG_CLEAR;
			q.prescaler <= srse_pkg::PRESC_CLEAR;
			q.file_wr.we <= 1'b0;
			q.file_wr.addr <= srse_pkg::FADDR_RST;
			q.file_wr.data <= srse_pkg::ACC_RST;
			q.rdata <= srse_pkg::RDATA_IDLE;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign acc = q.acc;
	assign flags = q.flags;
	assign file_wr = q.file_wr;
	// RQ3 oscillator held off while asleep
	assign osc_stop = ~run_now;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_sleep;
		issued && instr.op == srse_pkg::SRSE_OP_SLEEP;
	endsequence
	sequence s_rot;
		issued && instr.op == srse_pkg::SRSE_OP_ROTATE && !acc_wr;
	endsequence
	sequence s_sub_lit;
		issued && instr.op == srse_pkg::SRSE_OP_SUB_LIT && !acc_wr;
	endsequence
	sequence s_sub_file;
		issued && instr.op == srse_pkg::SRSE_OP_SUB_FILE && !acc_wr;
	endsequence

	// RQ1 power-down status bits
	a_sleep_status_bits: assert property ( // RQ1
		s_sleep |=> !flags.power_down_flag && flags.timeout_flag)
		else $error("power-down status bits wrong");

	// RQ2 watchdog cleared
	a_sleep_watchdog_zero: assert property ( // RQ2
		s_sleep |=> q.watchdog_counter == srse_pkg::WDG_CLEAR
			&& q.prescaler == srse_pkg::PRESC_CLEAR)
		else $error("watchdog not cleared by power-down");

	// RQ3 oscillator halted
	a_sleep_osc_halt: assert property ( // RQ3
		s_sleep ##1 !wake_wr |=> osc_stop && !file_wr.we)
		else $error("oscillator running after power-down");

	// RQ4 rotate through carry
	a_rotate_value: assert property ( // RQ4
		s_rot |=> flags.carry == $past(instr.operand[0])
			&& flags.zero == $past(flags.zero)
			&& flags.nibble_carry_flag == $past(flags.nibble_carry_flag))
		else $error("rotate carry or flags wrong");

	// RQ5 rotate destination select
	a_rotate_dest: assert property ( // RQ5
		s_rot |=> (file_wr.we == $past(instr.dest))
			&& ($past(instr.dest) ? file_wr.data : acc)
			== {$past(flags.carry), $past(instr.operand[7:1])})
		else $error("rotate result misrouted");

	// RQ6 literal subtract result
	a_sub_lit_acc: assert property ( // RQ6
		s_sub_lit |=> !file_wr.we
			&& acc == 8'($past(instr.operand) - $past(acc)))
		else $error("literal subtract result wrong");

	// RQ7 literal borrow flags
	a_sub_lit_borrow: assert property ( // RQ7
		s_sub_lit |=> flags.carry == ($past(acc) <= $past(instr.operand))
			&& flags.nibble_carry_flag == ($past(acc[3:0])
			<= $past(instr.operand[3:0])))
		else $error("literal subtract borrow flags wrong");

	// RQ8 file borrow flags
	a_sub_file_borrow: assert property ( // RQ8
		s_sub_file |=> flags.carry == ($past(acc) <= $past(instr.operand))
			&& flags.nibble_carry_flag == ($past(acc[3:0])
			<= $past(instr.operand[3:0])))
		else $error("file subtract borrow flags wrong");

	// RQ9 file write-back
	a_sub_file_dest: assert property ( // RQ9
		s_sub_file ##0 instr.dest |=> file_wr.we
			&& file_wr.addr == $past(instr.addr)
			&& file_wr.data == 8'($past(instr.operand) - $past(acc)))
		else $error("file subtract write-back wrong");

	// RQ10 subtract zero flag
	a_sub_zero_flag: assert property ( // RQ10
		(s_sub_lit or s_sub_file) |=> flags.zero
			== ((($past(instr.operand) - $past(acc)) & 8'hff) == 0))
		else $error("subtract zero flag wrong");

	sequence s_asleep_instr;
		!run_now && instr.valid && !acc_wr;
	endsequence

	// RQ3 sleep ignores instructions
	a_sleep_ignore_instr: assert property ( // RQ3
		s_asleep_instr |=> acc == $past(acc) && flags == $past(flags)
			&& !file_wr.we)
		else $error("instruction executed while asleep");

	// RQ3 sleep held until wake
	a_sleep_hold: assert property ( // RQ3
		!run_now && !wake_wr |=> osc_stop)
		else $error("oscillator restarted without wake");

	// RQ2 watchdog frozen asleep
	a_sleep_wdg_frozen: assert property ( // RQ2
		!run_now |=> q.watchdog_counter == $past(q.watchdog_counter)
			&& q.prescaler == $past(q.prescaler))
		else $error("watchdog moved while asleep");

	// RQ9 difference into accumulator
	a_sub_file_acc: assert property ( // RQ9
		s_sub_file ##0 !instr.dest |=> !file_wr.we
			&& acc == 8'($past(instr.operand) - $past(acc)))
		else $error("file subtract accumulator result wrong");

	// RQ5 file destination keeps accumulator
	a_rotate_keep_acc: assert property ( // RQ5
		s_rot ##0 instr.dest |=> acc == $past(acc))
		else $error("rotate to file changed accumulator");

endmodule : srse_exec

// file: tb/srse_file_model.sv
// Data register file model standing behind the executor's write-back port
`timescale 1ns/1ps
module srse_file_model (
	input wire logic clk_sys,
	input wire srse_pkg::srse_file_wr_t file_wr,
	input wire logic [srse_pkg::FADDR_W-1:0] rd_addr,
	output logic [srse_pkg::DATA_W-1:0] rd_data
);
	logic [srse_pkg::DATA_W-1:0] mem [128];

	// Fixed fill so each address holds a different operand
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i * 37 + 11);
		end
	end

	always @(posedge clk_sys) begin
		if (file_wr.we) begin
			mem[file_wr.addr] <= file_wr.data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule : srse_file_model

// file: tb/srse_exec_bench.sv
// Self-checking testbench for the subtract, rotate and sleep executor
`timescale 1ns/1ps
module srse_exec_bench;
	logic clk_sys;
	logic rst;
	srse_pkg::srse_instr_t instr;
	logic [srse_pkg::RADDR_W-1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, acc, fm_data, e_acc, e_r, rv;
	logic reg_wr, reg_rd, osc_stop;
	srse_pkg::srse_flags_t flags;
	srse_pkg::srse_file_wr_t file_wr;
	logic [6:0] fm_addr;
	logic e_c, e_dc, e_z, e_pd, e_sl;
	int error_cnt, num_checks;

	srse_exec u_dut (.clk_sys(clk_sys), .rst(rst), .instr(instr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc(acc), .flags(flags),
		.file_wr(file_wr), .osc_stop(osc_stop));
	srse_file_model u_file (.clk_sys(clk_sys), .file_wr(file_wr),
		.rd_addr(fm_addr), .rd_data(fm_data));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : reg_read

	// Issues one instruction and predicts its accumulator, flag, oscillator and file-write effects
	task automatic exec(input srse_pkg::srse_op_t op, input logic dest,
		input logic [6:0] a, input logic [7:0] opnd);
		logic wr;
		wr = 1'b0;
		if (!e_sl) begin
			if (op == srse_pkg::SRSE_OP_SLEEP) begin
				e_sl = 1'b1;
				e_pd = 1'b0;
			end else if (op == srse_pkg::SRSE_OP_ROTATE) begin
				e_r = {e_c, opnd[7:1]};
				e_c = opnd[0];
				wr = dest;
			end else begin
				e_r = opnd - e_acc;
				e_c = e_acc <= opnd;
				e_dc = e_acc[3:0] <= opnd[3:0];
				e_z = e_r == 8'h00;
				wr = dest && op == srse_pkg::SRSE_OP_SUB_FILE;
			end
			if (op != srse_pkg::SRSE_OP_SLEEP && !wr) begin
				e_acc = e_r;
			end
		end
		@(posedge clk_sys);
		instr <= '{1'b1, op, dest, a, opnd};
		@(posedge clk_sys);
		instr.valid <= 1'b0;
		#1;
		check(acc, e_acc);
		check(flags, {e_c, e_dc, e_z, e_pd, 1'b1});
		check(osc_stop, e_sl);
		check(file_wr.we, wr);
		if (wr) begin
			check({file_wr.addr, file_wr.data}, {a, e_r});
			@(posedge clk_sys);
			#1;
			check(fm_data, e_r);
		end
	endtask : exec

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_sub_lit;
		logic [7:0] wa [5] = '{8'h05, 8'h06, 8'h0f, 8'h00, 8'hff};
		logic [7:0] ka [5] = '{8'h05, 8'h05, 8'h10, 8'hff, 8'h00};
		for (int i = 0; i < 5; i++) begin
			reg_write(srse_pkg::REG_ACC, wa[i]);
			e_acc = wa[i];
			exec(srse_pkg::SRSE_OP_SUB_LIT, 1'b1, 7'h11, ka[i]);
		end
		reg_read(srse_pkg::REG_ACC);
		check(rv, e_acc);
		$display("t_sub_lit done");
	endtask : t_sub_lit

	task automatic t_file_ops;
		reg_write(srse_pkg::REG_ACC, 8'h30);
		e_acc = 8'h30;
		for (int i = 0; i < 4; i++) begin
			fm_addr = i[0] ? 7'h7f : 7'h00;
			#1;
			exec(i[1] ? srse_pkg::SRSE_OP_ROTATE : srse_pkg::SRSE_OP_SUB_FILE,
				1'b1, fm_addr, fm_data);
			exec(i[1] ? srse_pkg::SRSE_OP_ROTATE : srse_pkg::SRSE_OP_SUB_FILE,
				1'b0, fm_addr, fm_data);
		end
		$display("t_file_ops done");
	endtask : t_file_ops

	task automatic t_sleep;
		reg_read(srse_pkg::REG_STATUS);
		check(rv[4:3], 2'h3);
		reg_read(4'hf);
		check(rv, 8'h00);
		reg_write(srse_pkg::REG_CTRL, 8'h02);
		reg_read(srse_pkg::REG_CTRL);
		check(rv, 8'h02);
		repeat (300) @(posedge clk_sys);
		reg_read(srse_pkg::REG_WATCHDOG);
		check(rv != 8'h00, 1'b1);
		exec(srse_pkg::SRSE_OP_SLEEP, 1'b0, 7'h00, 8'h00);
		reg_read(srse_pkg::REG_WATCHDOG);
		check(rv, 8'h00);
		reg_read(srse_pkg::REG_STATUS);
		check(rv[5:3], 3'h6);
		exec(srse_pkg::SRSE_OP_SUB_LIT, 1'b0, 7'h00, 8'h99);
		reg_write(srse_pkg::REG_CTRL, 8'h01);
		e_sl = 1'b0;
		exec(srse_pkg::SRSE_OP_ROTATE, 1'b0, 7'h00, 8'h81);
		$display("t_sleep done");
	endtask : t_sleep

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		wrap_up();
	end

	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata, fm_addr} = '0;
		rst = 1'b1;
		instr = '0;
		{error_cnt, num_checks} = '0;
		{e_acc, e_c, e_dc, e_z, e_sl} = '0;
		e_pd = 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_sub_lit();
		t_file_ops();
		t_sleep();
		wrap_up();
	end
endmodule : srse_exec_bench
